// ### pkg/mmlrc_pkg.sv
// shared constants and types of the memory matrix lock and clocking block
package mmlrc_pkg;

  // address decode: top three bits pick a 512MB region
  localparam int REGION_HI = 31;
  localparam int REGION_LO = 29;
  localparam logic [2:0] REGION_BOOT = 3'h0;

  // controller indices
  localparam int NCTL     = 2;
  localparam int CTL_DYN  = 0;
  localparam int CTL_STAT = 1;

  // per-chip clock outputs of each memory side
  localparam int NCHIP = 4;

  // clock of the whole block, 125 MHz
  localparam int CLK_PERIOD_NS = 8;

  // crossing latency in cycles, inserted transfer to completion
  localparam int LAT_SYNC_FAST = 1;  // memory clock a multiple of hclk
  localparam int LAT_SYNC      = 2;  // equal or hclk a multiple
  localparam int LAT_ASYNC_BASE = 2; // plus synchroniser stages
  localparam int SYNC_STAGES_DEF = 2;

  // static chip 0 width when no boot alias is active
  localparam logic [1:0] CS0_WIDTH_DEF = 2'h1;

  // reset values of the tie-off outputs of the master end
  localparam logic [1:0] BOOT_WIDTH_RST = 2'h0;

  // clock crossing choice at the master end
  typedef enum logic [1:0] {
    MMLRC_CK_FULL   = 2'b00,
    MMLRC_CK_SLOWM  = 2'b01,
    MMLRC_CK_FASTM  = 2'b10,
    MMLRC_CK_ASYNC  = 2'b11
  } mmlrc_ckmode_t;

  // lock state of one controller
  typedef enum logic [1:0] {
    MMLRC_LK_FREE    = 2'b00,
    MMLRC_LK_HELD    = 2'b01,
    MMLRC_LK_RELEASE = 2'b10
  } mmlrc_lock_t;

endpackage

// ### pkg/mmlrc_if.sv
// link between the bus masters with tie-off logic and the matrix
`timescale 1ns/10ps
interface mmlrc_if #(
  parameter int NP = 2
);
  import mmlrc_pkg::*;

  // request per master port
  logic [NP-1:0]        req_valid;
  logic [NP-1:0][31:0]  req_addr;
  logic [NP-1:0]        req_lock;
  logic [NP-1:0]        lock_seq;
  logic [NP-1:0]        req_ready;
  logic [NP-1:0]        resp_valid;

  // boot and remap tie-offs
  logic                 remap;
  logic                 cs0_alias;
  logic [1:0]           boot_width;

  // crossing tie-offs of both memory paths
  logic                 dyn_bus_sync;
  logic                 dyn_mem_sync;
  logic                 dyn_faster;
  logic                 stat_bus_sync;
  logic                 stat_mem_sync;
  logic                 stat_faster;

  // bus-side clock run of each controller
  logic                 dyn_bus_on;
  logic                 stat_bus_on;

  modport master (
    output req_valid, req_addr, req_lock, lock_seq,
    output remap, cs0_alias, boot_width,
    output dyn_bus_sync, dyn_mem_sync, dyn_faster,
    output stat_bus_sync, stat_mem_sync, stat_faster,
    output dyn_bus_on, stat_bus_on,
    input  req_ready, resp_valid
  );

  modport matrix (
    input  req_valid, req_addr, req_lock, lock_seq,
    input  remap, cs0_alias, boot_width,
    input  dyn_bus_sync, dyn_mem_sync, dyn_faster,
    input  stat_bus_sync, stat_mem_sync, stat_faster,
    input  dyn_bus_on, stat_bus_on,
    output req_ready, resp_valid
  );

endinterface

// ### verilog/mmlrc_master.sv
// master end: request ports, lock sequence tracking and tie-offs
`timescale 1ns/10ps
module mmlrc_master
  import mmlrc_pkg::*;
#(
  parameter int NP = 2
) (
  input  wire logic                CLK,
  input  wire logic                RST_N,
  mmlrc_if.master                  LNK,
  input  wire logic [NP-1:0]       U_START,
  input  wire logic [NP-1:0][31:0] U_ADDR,
  input  wire logic [NP-1:0]       U_LOCK,
  input  wire logic                U_REMAP,
  input  wire logic                U_CS0_ALIAS,
  input  wire logic [1:0]          U_BOOT_WIDTH,
  input  wire mmlrc_ckmode_t       U_DYN_MODE,
  input  wire mmlrc_ckmode_t       U_STAT_MODE,
  input  wire logic                U_DYN_BUS_ON,
  input  wire logic                U_STAT_BUS_ON,
  output logic      [NP-1:0]       U_BUSY,
  output logic      [NP-1:0]       U_DONE,
  output logic      [NP-1:0]       U_LOCK_ERR
);

  typedef struct packed {
    logic [NP-1:0]       valid;
    logic [NP-1:0][31:0] addr;
    logic [NP-1:0]       lock;
    logic [NP-1:0]       lseq;
    logic [NP-1:0]       lreg_ok;
    logic [NP-1:0][2:0]  lreg;
    logic [NP-1:0]       wait_resp;
    logic [NP-1:0]       done;
    logic [NP-1:0]       err;
    logic [NP-1:0]       busy;
    logic                remap;
    logic                alias_on;
    logic [1:0]          bwidth;
    logic [2:0]          dyn_tie;
    logic [2:0]          stat_tie;
    logic                dyn_on;
    logic                stat_on;
  } mmlrc_mst_st_t;

  mmlrc_mst_st_t st;
  mmlrc_mst_st_t next_st;

  // tie-off triple {bus sync, mem sync, faster} for a crossing choice
  function automatic logic [2:0] tie_of(input mmlrc_ckmode_t m);
    logic [2:0] t;
    t = 3'h0;
    unique case (m)
      MMLRC_CK_FULL:  t = 3'h6;
      MMLRC_CK_SLOWM: t = 3'h6;
      MMLRC_CK_FASTM: t = 3'h7;
      MMLRC_CK_ASYNC: t = 3'h0;
    endcase
    return t;
  endfunction

  // request handshake, lock region check and tie-off drive
  always_comb begin
    logic [2:0] rg;
    rg = 3'h0;
    next_st = st;
    next_st.done = '0;
    next_st.err = '0;
    // one clock feeds matrix and both bus sides
    next_st.remap = U_REMAP;
    next_st.alias_on = U_CS0_ALIAS;
    next_st.bwidth = U_BOOT_WIDTH;
    next_st.dyn_tie = tie_of(U_DYN_MODE);
    next_st.stat_tie = tie_of(U_STAT_MODE);
    next_st.dyn_on = U_DYN_BUS_ON;
    next_st.stat_on = U_STAT_BUS_ON;
    for (int p = 0; p < NP; p++) begin
      rg = U_ADDR[p][REGION_HI:REGION_LO];
      // sequence ends when the user drops lock while idle
      if (!U_LOCK[p] && !st.valid[p] && !st.wait_resp[p]) begin
        next_st.lseq[p] = 1'b0;
        next_st.lreg_ok[p] = 1'b0;
      end
      if (st.valid[p] && LNK.req_ready[p]) begin
        next_st.valid[p] = 1'b0;
        next_st.wait_resp[p] = 1'b1;
      end
      if (st.wait_resp[p] && LNK.resp_valid[p]) begin
        next_st.wait_resp[p] = 1'b0;
        next_st.done[p] = 1'b1;
      end
      if (U_START[p] && !st.valid[p] && !st.wait_resp[p]) begin
        // locked beats stay in one 512MB region
        if (U_LOCK[p] && st.lreg_ok[p] && rg != st.lreg[p]) begin
          next_st.err[p] = 1'b1;
        end else begin
          next_st.valid[p] = 1'b1;
          next_st.addr[p] = U_ADDR[p];
          next_st.lock[p] = U_LOCK[p];
          if (U_LOCK[p]) begin
            next_st.lseq[p] = 1'b1;
            next_st.lreg_ok[p] = 1'b1;
            next_st.lreg[p] = rg;
          end
        end
      end
    end
    // busy kept in a flop so the output carries no gate
    next_st.busy = next_st.valid | next_st.wait_resp;
  end

  // state register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
      st.bwidth <= BOOT_WIDTH_RST;
      st.dyn_tie <= 3'h6;  // safe default: fully synchronous
      st.stat_tie <= 3'h6;
    end else begin
      st <= next_st;
    end
  end

  // link and user outputs straight from flops
  assign LNK.req_valid = st.valid;
  assign LNK.req_addr = st.addr;
  assign LNK.req_lock = st.lock;
  assign LNK.lock_seq = st.lseq;
  assign LNK.remap = st.remap;
  assign LNK.cs0_alias = st.alias_on;
  assign LNK.boot_width = st.bwidth;
  assign LNK.dyn_bus_sync = st.dyn_tie[2];
  assign LNK.dyn_mem_sync = st.dyn_tie[1];
  assign LNK.dyn_faster = st.dyn_tie[0];
  assign LNK.stat_bus_sync = st.stat_tie[2];
  assign LNK.stat_mem_sync = st.stat_tie[1];
  assign LNK.stat_faster = st.stat_tie[0];
  assign LNK.dyn_bus_on = st.dyn_on;
  assign LNK.stat_bus_on = st.stat_on;
  assign U_BUSY = st.busy;
  assign U_DONE = st.done;
  assign U_LOCK_ERR = st.err;

endmodule

// ### verilog/mmlrc_matrix.sv
// matrix end: region decode, round robin, locking and memory clocks
`timescale 1ns/10ps
module mmlrc_matrix
  import mmlrc_pkg::*;
#(
  parameter int NP          = 2,
  parameter int SYNC_STAGES = SYNC_STAGES_DEF
) (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  mmlrc_if.matrix                LNK,
  input  wire logic [NCHIP-1:0]  DYN_CHIP_NEED,
  input  wire logic [NCHIP-1:0]  STAT_CHIP_NEED,
  input  wire logic              STAT_FB_CLK,
  output logic      [NCTL-1:0]   CTL_XFER_VALID,
  output logic      [31:0]       CTL_XFER_ADDR,
  output logic      [NCTL-1:0]   CTL_XFER_UNLOCK,
  output logic      [NCTL-1:0]   CTL_LOCKED,
  output logic                   STAT_CS0_HIT,
  output logic                   STAT_CS0_ALIAS_ON,
  output logic      [1:0]        STAT_CS0_WIDTH,
  output logic                   STAT_MAX_TIMING,
  output logic      [NCHIP-1:0]  DYN_CLK_OUT,
  output logic      [NCHIP-1:0]  STAT_CLK_OUT,
  output logic                   STAT_FB_SEEN
);

  localparam int PW = (NP > 1) ? $clog2(NP) : 1;
  localparam int PD = LAT_ASYNC_BASE + SYNC_STAGES;
  localparam int CW = $clog2(PD + 1);

  typedef struct packed {
    logic [NP-1:0]                   ready;
    logic [NP-1:0]                   resp;
    mmlrc_lock_t [NCTL-1:0]          lk;
    logic [NCTL-1:0][PW-1:0]         owner;
    logic [NCTL-1:0][PD-1:0]         pv;
    logic [NCTL-1:0][PD-1:0]         pdum;
    logic [NCTL-1:0][PD-1:0][PW-1:0] pid;
    logic [NCTL-1:0][CW-1:0]         outst;
    logic [PW-1:0]                   rr;
    logic [NCTL-1:0]                 xfer_v;
    logic [31:0]                     xfer_addr;
    logic [NCTL-1:0]                 xfer_unl;
    logic [NCTL-1:0]                 locked;
    logic                            cs0_hit;
    logic                            cs0_on;
    logic [1:0]                      cs0_w;
    logic                            max_tim;
    logic [NCHIP-1:0]                dclk;
    logic [NCHIP-1:0]                sclk;
    logic                            fb_q;
    logic                            fb_seen;
  } mmlrc_mtx_st_t;

  mmlrc_mtx_st_t st;
  mmlrc_mtx_st_t next_st;

  // cycles from insertion to completion for one crossing setting
  function automatic int lat_of(input logic bsync, input logic msync,
                                input logic fast);
    int l;
    l = LAT_SYNC;
    if (bsync && msync) begin
      l = fast ? LAT_SYNC_FAST : LAT_SYNC;
    end else begin
      // async crossing pays the synchroniser stages
      l = LAT_ASYNC_BASE + SYNC_STAGES;
    end
    return l;
  endfunction

  // owning controller of an address
  function automatic int target_of(input logic [31:0] a, input logic rmp);
    logic [2:0] rg;
    int t;
    // region from the top three bits
    rg = a[REGION_HI:REGION_LO];
    // odd regions static, even ones dynamic
    t = rg[0] ? CTL_STAT : CTL_DYN;
    // remap moves region zero to the static side
    if (rg == REGION_BOOT) begin
      t = rmp ? CTL_STAT : CTL_DYN;
    end
    return t;
  endfunction

  // pipe model, lock tracking and arbitration
  always_comb begin
    int lat [NCTL];
    logic [NCTL-1:0] on;
    logic [NCTL-1:0] used;
    logic granted;
    logic ok;
    logic done;
    int p;
    int t;
    for (int c = 0; c < NCTL; c++) begin
      lat[c] = LAT_SYNC;
    end
    on = '0;
    used = '0;
    granted = 1'b0;
    ok = 1'b0;
    done = 1'b0;
    p = 0;
    t = 0;
    next_st = st;
    next_st.ready = '0;
    next_st.resp = '0;
    next_st.xfer_v = '0;
    next_st.xfer_unl = '0;
    next_st.cs0_hit = 1'b0;
    // async dynamic crossing uses extra stages
    lat[CTL_DYN] = lat_of(LNK.dyn_bus_sync, LNK.dyn_mem_sync,
                          LNK.dyn_faster);
    // async static crossing uses extra stages
    lat[CTL_STAT] = lat_of(LNK.stat_bus_sync, LNK.stat_mem_sync,
                           LNK.stat_faster);
    // a stopped bus-side clock freezes that controller only
    on[CTL_DYN] = LNK.dyn_bus_on;
    on[CTL_STAT] = LNK.stat_bus_on;
    // advance each controller pipe and retire its oldest entry
    for (int c = 0; c < NCTL; c++) begin
      if (on[c]) begin
        done = st.pv[c][lat[c]-1];
        for (int i = 0; i < PD; i++) begin
          if (i == 0 || i >= lat[c]) begin
            next_st.pv[c][i] = 1'b0;
          end else begin
            next_st.pv[c][i] = st.pv[c][i-1];
            next_st.pdum[c][i] = st.pdum[c][i-1];
            next_st.pid[c][i] = st.pid[c][i-1];
          end
        end
        if (done) begin
          next_st.outst[c] = next_st.outst[c] - CW'(1);
          if (!st.pdum[c][lat[c]-1]) begin
            next_st.resp[st.pid[c][lat[c]-1]] = 1'b1;
          end else if (st.lk[c] == MMLRC_LK_RELEASE) begin
            next_st.lk[c] = MMLRC_LK_FREE;
          end
        end
        // owner dropped its sequence: insert unlock transfer
        if (st.lk[c] == MMLRC_LK_HELD && !LNK.lock_seq[st.owner[c]]) begin
          next_st.pv[c][0] = 1'b1;
          next_st.pdum[c][0] = 1'b1;
          next_st.pid[c][0] = st.owner[c];
          next_st.outst[c] = next_st.outst[c] + CW'(1);
          next_st.lk[c] = MMLRC_LK_RELEASE;
          next_st.xfer_v[c] = 1'b1;
          next_st.xfer_unl[c] = 1'b1;
          used[c] = 1'b1;
        end
      end
    end
    // one grant per cycle, search starts after the last winner
    for (int k = 0; k < NP; k++) begin
      p = (int'(st.rr) + k) % NP;
      if (!granted && LNK.req_valid[p] && !st.ready[p]) begin
        t = target_of(LNK.req_addr[p], LNK.remap);
        ok = on[t] && !used[t];
        unique case (st.lk[t])
          // a locked request waits for an idle target
          MMLRC_LK_FREE:    ok = ok && (!LNK.req_lock[p] || st.outst[t] == '0);
          // only the owner, and only its locked beats
          MMLRC_LK_HELD:    ok = ok && st.owner[t] == PW'(p)
                                 && LNK.req_lock[p];
          MMLRC_LK_RELEASE: ok = 1'b0;
          default:          ok = 1'b0;
        endcase
        if (ok) begin
          granted = 1'b1;
          next_st.ready[p] = 1'b1;
          next_st.rr = PW'((p + 1) % NP);
          next_st.pv[t][0] = 1'b1;
          next_st.pdum[t][0] = 1'b0;
          next_st.pid[t][0] = PW'(p);
          next_st.outst[t] = next_st.outst[t] + CW'(1);
          next_st.xfer_v[t] = 1'b1;
          next_st.xfer_addr = LNK.req_addr[p];
          // boot alias answers static chip zero at the base
          next_st.cs0_hit = (t == CTL_STAT) && LNK.cs0_alias
              && LNK.req_addr[p][REGION_HI:REGION_LO] == REGION_BOOT;
          if (LNK.req_lock[p] && st.lk[t] == MMLRC_LK_FREE) begin
            next_st.lk[t] = MMLRC_LK_HELD;
            next_st.owner[t] = PW'(p);
          end
        end
      end
    end
    for (int c = 0; c < NCTL; c++) begin
      next_st.locked[c] = next_st.lk[c] != MMLRC_LK_FREE;
    end
    // alias takes boot width and slowest timing
    next_st.cs0_on = LNK.cs0_alias;
    next_st.cs0_w = LNK.cs0_alias ? LNK.boot_width : CS0_WIDTH_DEF;
    next_st.max_tim = LNK.cs0_alias;
    // dynamic and static chip clocks toggle only where needed
    for (int i = 0; i < NCHIP; i++) begin
      next_st.dclk[i] = DYN_CHIP_NEED[i] & ~st.dclk[i];
      next_st.sclk[i] = STAT_CHIP_NEED[i] & ~st.sclk[i];
    end
    // feedback clock activity is sticky until reset
    next_st.fb_q = STAT_FB_CLK;
    if (STAT_FB_CLK != st.fb_q) begin
      next_st.fb_seen = 1'b1;
    end
  end

  // whole bus domain cleared by the one reset, except chip 0 width, which loads CS0_WIDTH_DEF
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
      st.cs0_w <= CS0_WIDTH_DEF;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign LNK.req_ready = st.ready;
  assign LNK.resp_valid = st.resp;
  assign CTL_XFER_VALID = st.xfer_v;
  assign CTL_XFER_ADDR = st.xfer_addr;
  assign CTL_XFER_UNLOCK = st.xfer_unl;
  assign CTL_LOCKED = st.locked;
  assign STAT_CS0_HIT = st.cs0_hit;
  assign STAT_CS0_ALIAS_ON = st.cs0_on;
  assign STAT_CS0_WIDTH = st.cs0_w;
  assign STAT_MAX_TIMING = st.max_tim;
  assign DYN_CLK_OUT = st.dclk;
  assign STAT_CLK_OUT = st.sclk;
  assign STAT_FB_SEEN = st.fb_seen;

endmodule

// ### testbench/mmlrc_asserts.sv
// concurrent checks on the link between the master end and the matrix end
`timescale 1ns/10ps
module mmlrc_asserts
  import mmlrc_pkg::*;
#(
  parameter int SYNC_STAGES = SYNC_STAGES_DEF
) (
  input wire logic             CLK,
  input wire logic             RST_N,
  input wire logic [1:0]       req_valid,
  input wire logic [1:0][31:0] req_addr,
  input wire logic [1:0]       req_lock,
  input wire logic [1:0]       lock_seq,
  input wire logic [1:0]       req_ready,
  input wire logic [1:0]       resp_valid,
  input wire logic             remap,
  input wire logic             dyn_bus_sync,
  input wire logic             dyn_mem_sync,
  input wire logic             dyn_faster,
  input wire logic             stat_bus_sync,
  input wire logic             stat_mem_sync,
  input wire logic             stat_faster,
  input wire logic             stat_bus_on
);
  logic [1:0][2:0] cnt;
  logic [1:0]      busy;
  logic [1:0]      btgt;
  logic            held;
  logic            htgt;
  logic            pend1;

  function automatic logic tgt(input logic [31:0] a);
    return a[REGION_LO] | (a[REGION_HI:REGION_LO] == REGION_BOOT && remap);
  endfunction

  // cycles from take answer to completion; odd tie combos count as async
  function automatic logic [2:0] lat(input logic st);
    logic s;
    logic f;
    s = st ? stat_bus_sync & stat_mem_sync : dyn_bus_sync & dyn_mem_sync;
    f = st ? stat_faster : dyn_faster;
    if (!s)
      return 3'(LAT_ASYNC_BASE + SYNC_STAGES);
    return f ? 3'(LAT_SYNC_FAST) : 3'(LAT_SYNC);
  endfunction

  // port 1 work still open on port 0's target, conservative view
  assign pend1 = (busy[1] | req_ready[1]) & ~resp_valid[1]
               & ((busy[1] ? btgt[1] : tgt(req_addr[1])) == tgt(req_addr[0]));

  // completion countdown, open transfers and lock owner tracking
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt  <= '0;
      busy <= '0;
      btgt <= '0;
      held <= 1'b0;
      htgt <= 1'b0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (req_ready[p]) begin
          cnt[p]  <= lat(tgt(req_addr[p]));
          busy[p] <= 1'b1;
          btgt[p] <= tgt(req_addr[p]);
        end else begin
          cnt[p]  <= cnt[p] - ((cnt[p] != 3'h0) ? 3'h1 : 3'h0);
          busy[p] <= busy[p] & ~resp_valid[p];
        end
      end
      if (req_ready[0] & req_lock[0]) begin
        held <= 1'b1;
        htgt <= tgt(req_addr[0]);
      end else if (!lock_seq[0])
        held <= 1'b0;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  reset_quiet_a: assert property (
    $rose(RST_N) |-> !req_ready && !resp_valid)
    else $error("link answer active right after reset");
  one_grant_a: assert property ($onehot0(req_ready))
    else $error("two ports granted in one cycle");
  ready_cause_a: assert property (
    req_ready[1] |-> $past(req_valid[1]))
    else $error("ready without a request");
  ready_pulse_a: assert property (req_ready[0] |=> !req_ready[0])
    else $error("ready longer than one cycle");
  stat_gate_a: assert property (
    req_ready[0] && tgt(req_addr[0]) |-> $past(stat_bus_on))
    else $error("static side served while its clock is stopped");
  resp_timing_a: assert property (
    resp_valid[0] == (cnt[0] == 3'h1) && resp_valid[1] == (cnt[1] == 3'h1))
    else $error("completion latency wrong for crossing mode");
  lock_drain_a: assert property (
    req_ready[0] && req_lock[0] && !held |-> !$past(pend1))
    else $error("locked take while target still busy");
  lock_owner_a: assert property (
    held && lock_seq[0] && req_ready[1] |-> tgt(req_addr[1]) != htgt)
    else $error("locked target served another port");
endmodule

// ### testbench/mmlrc_bench.sv
// self-checking bench: master end and matrix end joined by the link
`timescale 1ns/10ps
module mmlrc_bench
  import mmlrc_pkg::*;
;
  logic             clk = 1'b0;
  logic             rst_n;
  logic [1:0]       u_start;
  logic [1:0][31:0] u_addr;
  logic [1:0]       u_lock;
  logic             u_remap;
  logic             u_alias;
  logic [1:0]       u_bw;
  mmlrc_ckmode_t    dmode;
  mmlrc_ckmode_t    smode;
  logic             u_dyn_on;
  logic             u_stat_on;
  logic [3:0]       dneed;
  logic [3:0]       sneed;
  logic             fb_clk;
  logic [1:0]       busy;
  logic [1:0]       done;
  logic [1:0]       lock_err;
  logic [1:0]       xv;
  logic [1:0]       xu;
  logic [1:0]       locked;
  logic             alias_on;
  logic [1:0]       width;
  logic             max_t;
  logic [3:0]       dclk;
  logic [3:0]       sclk;
  logic             fb_seen;
  logic [31:0]      xa;
  logic             hit;
  logic             hit_q;
  int               errors = 0;
  int               tests_run = 0;
  int               first = -1;
  int               cyc = 0;
  int               m;
  logic             err;
  logic             st;
  logic [4:0]       k;
  logic [2:0]       exp;
  logic [3:0]       d0;
  logic [3:0]       s0;

  // clock at 125 MHz
  // one clock for both ends
  always #4 clk = ~clk;

  mmlrc_if #(.NP(2)) lnk ();
  mmlrc_master #(.NP(2)) mmlrc_master_i (
    .CLK(clk), .RST_N(rst_n), .LNK(lnk), .U_START(u_start),
    .U_ADDR(u_addr), .U_LOCK(u_lock), .U_REMAP(u_remap),
    .U_CS0_ALIAS(u_alias), .U_BOOT_WIDTH(u_bw), .U_DYN_MODE(dmode),
    .U_STAT_MODE(smode), .U_DYN_BUS_ON(u_dyn_on),
    .U_STAT_BUS_ON(u_stat_on), .U_BUSY(busy), .U_DONE(done),
    .U_LOCK_ERR(lock_err));
  mmlrc_matrix #(.NP(2), .SYNC_STAGES(SYNC_STAGES_DEF)) mmlrc_matrix_i (
    .CLK(clk), .RST_N(rst_n), .LNK(lnk), .DYN_CHIP_NEED(dneed),
    .STAT_CHIP_NEED(sneed), .STAT_FB_CLK(fb_clk), .CTL_XFER_VALID(xv),
    .CTL_XFER_ADDR(xa), .CTL_XFER_UNLOCK(xu), .CTL_LOCKED(locked),
    .STAT_CS0_HIT(hit), .STAT_CS0_ALIAS_ON(alias_on),
    .STAT_CS0_WIDTH(width), .STAT_MAX_TIMING(max_t),
    .DYN_CLK_OUT(dclk), .STAT_CLK_OUT(sclk), .STAT_FB_SEEN(fb_seen));
  mmlrc_asserts #(.SYNC_STAGES(SYNC_STAGES_DEF)) mmlrc_asserts_i (
    .CLK(clk), .RST_N(rst_n), .req_valid(lnk.req_valid),
    .req_addr(lnk.req_addr), .req_lock(lnk.req_lock),
    .lock_seq(lnk.lock_seq), .req_ready(lnk.req_ready),
    .resp_valid(lnk.resp_valid), .remap(lnk.remap),
    .dyn_bus_sync(lnk.dyn_bus_sync), .dyn_mem_sync(lnk.dyn_mem_sync),
    .dyn_faster(lnk.dyn_faster), .stat_bus_sync(lnk.stat_bus_sync),
    .stat_mem_sync(lnk.stat_mem_sync), .stat_faster(lnk.stat_faster),
    .stat_bus_on(lnk.stat_bus_on));

  // compare and count
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one request from port p; ctl is the controller expected to take it
  task automatic xfer(input int p, input logic [31:0] a, input logic lk,
                      input logic [1:0] ctl, output logic e);
    int n;
    u_start[p] <= 1'b1;
    u_addr[p] <= a;
    u_lock[p] <= lk;
    @(posedge clk);
    u_start[p] <= 1'b0;
    n = 0;
    while (lnk.req_ready[p] !== 1'b1 && lock_err[p] !== 1'b1 && n < 80) begin
      @(posedge clk);
      n++;
    end
    e = lock_err[p];
    if (e === 1'b1)
      return;
    if (first < 0)
      first = p;
    check(xv === ctl, "controller choice");
    check(xa === a, "transfer address");
    hit_q = hit;
    while (done[p] !== 1'b1 && n < 80) begin
      @(posedge clk);
      n++;
    end
    check(n < 80, "transfer hung");
  endtask

  // hang guard, far above the several hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errors++;
      $display("MISMATCH at %0t: run timed out", $time);
      stop_test();
    end
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    u_start = '0;
    u_addr = '0;
    u_lock = '0;
    u_remap = 1'b0;
    u_alias = 1'b0;
    u_bw = 2'h0;
    dmode = MMLRC_CK_FULL;
    smode = MMLRC_CK_FULL;
    u_dyn_on = 1'b1;
    u_stat_on = 1'b1;
    dneed = 4'h0;
    sneed = 4'h0;
    fb_clk = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(fb_seen === 1'b0 && width === CS0_WIDTH_DEF, "reset");
    // mapped addresses and documented modes only
    // every crossing mode, every region at its top word, both remaps
    for (m = 0; m < 4; m++) begin
      dmode <= mmlrc_ckmode_t'(m[1:0]);
      smode <= mmlrc_ckmode_t'(m[1:0]);
      repeat (3) @(posedge clk);
      exp = (m == 3) ? 3'h0 : ((m == 2) ? 3'h7 : 3'h6);
      check({lnk.dyn_bus_sync, lnk.dyn_mem_sync, lnk.dyn_faster} === exp,
            "dyn ties");
      check({lnk.stat_bus_sync, lnk.stat_mem_sync, lnk.stat_faster} === exp,
            "stat ties");
      for (k = 0; k < 16; k++) begin
        u_remap <= k[3];
        repeat (2) @(posedge clk);
        st = k[0] | (k[2:0] == 3'h0 && k[3]);
        xfer(int'(k[0]), {k[2:0], 29'h1ffffffc}, 1'b0, {st, ~st}, err);
      end
    end
    end_test("decode");
    dmode <= MMLRC_CK_FASTM;
    u_remap <= 1'b0;
    repeat (3) @(posedge clk);
    // last winner loses the next contention
    for (m = 0; m < 2; m++) begin
      xfer(m, 32'h40000000, 1'b0, 2'h1, err);
      first = -1;
      fork
        xfer(0, 32'h40000004, 1'b0, 2'h1, err);
        xfer(1, 32'h80000000, 1'b0, 2'h1, err);
      join
      check(first == 1 - m, "round robin order");
    end
    end_test("arbitration");
    // locked beat waits for open static work, then owns the static side
    first = -1;
    fork
      xfer(1, 32'h20000000, 1'b0, 2'h2, err);
      begin
        @(posedge clk);
        xfer(0, 32'h20000010, 1'b1, 2'h2, err);
      end
    join
    check(first == 1 && locked === 2'h2, "lock after drain");
    xfer(0, 32'h40000000, 1'b1, 2'h1, err);
    check(err === 1'b1, "locked beat leaves region");
    first = -1;
    fork
      xfer(1, 32'h20000020, 1'b0, 2'h2, err);
      begin
        xfer(0, 32'h20000030, 1'b1, 2'h2, err);
        u_lock[0] <= 1'b0;
        m = 0;
        while (xu[1] !== 1'b1 && m < 40) begin
          @(posedge clk);
          m++;
        end
        check(m < 40, "unlock transfer inserted");
      end
    join
    check(first == 0 && locked === 2'h0, "owner first, lock freed");
    end_test("lock");
    // static bus clock stopped: dynamic traffic still flows
    u_stat_on <= 1'b0;
    repeat (3) @(posedge clk);
    fork
      xfer(0, 32'h60000000, 1'b0, 2'h2, err);
      begin
        xfer(1, 32'hc0000000, 1'b0, 2'h1, err);
        check(busy[0] === 1'b1, "stopped side holds request");
        u_stat_on <= 1'b1;
      end
    join
    // dynamic bus clock stopped: static traffic still flows
    u_dyn_on <= 1'b0;
    repeat (3) @(posedge clk);
    fork
      xfer(1, 32'h40000000, 1'b0, 2'h1, err);
      begin
        xfer(0, 32'h20000000, 1'b0, 2'h2, err);
        check(busy[1] === 1'b1, "stopped dyn side holds");
        u_dyn_on <= 1'b1;
      end
    join
    end_test("clock stop");
    u_alias <= 1'b1;
    u_bw <= 2'h2;
    u_remap <= 1'b1;
    repeat (3) @(posedge clk);
    check(alias_on === 1'b1 && width === 2'h2 && max_t === 1'b1,
          "boot alias on");
    // region zero under remap reaches static chip zero
    xfer(0, 32'h00000100, 1'b0, 2'h2, err);
    check(hit_q === 1'b1, "boot alias hit");
    u_alias <= 1'b0;
    u_remap <= 1'b0;
    repeat (3) @(posedge clk);
    check(alias_on === 1'b0 && width === CS0_WIDTH_DEF && max_t === 1'b0,
          "boot alias off");
    end_test("alias");
    // chip clocks toggle only where needed
    dneed <= 4'h5;
    sneed <= 4'ha;
    repeat (3) @(posedge clk);
    d0 = dclk;
    s0 = sclk;
    @(posedge clk);
    check((d0 ^ dclk) === 4'h5 && (dclk & 4'ha) === 4'h0, "dyn clk");
    check((s0 ^ sclk) === 4'ha && (sclk & 4'h5) === 4'h0, "stat clk");
    dneed <= 4'h0;
    sneed <= 4'h0;
    fb_clk <= 1'b1;
    repeat (3) @(posedge clk);
    check(dclk === 4'h0 && sclk === 4'h0 && fb_seen === 1'b1,
          "clocks stopped");
    end_test("chip clocks");
    stop_test();
  end
endmodule
